/* core/sbt_pkg.sv */
// Purpose: Shared constants, types and decoders for the sink blink timer
// Assumes: 200 MHz core clock, 100 ms timebase tick
// Notes: Durations are held in whole ticks so every setting is exact
package sbt_pkg;

  // Register offsets behind the serial control port
  localparam logic [7:0] ADDR_SINK_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_BLINK_TIME = 8'h11;

  // Values after reset
  localparam logic [6:0] RST_SINK_ENABLE = 7'h00;
  localparam logic [7:0] RST_BLINK_TIME = 8'h00;

  // Field positions
  localparam int ON_FIELD_LSB = 6;
  localparam int OFF_FIELD_STRIDE = 2;
  localparam int FIRST_SINK_EN_BIT = 4;
  localparam int SINK_COUNT = 3;
  localparam int ENABLE_WIDTH = 7;

  // Timebase: tick period and the clock rate it is derived from
  localparam int TICK_MS = 100;
  localparam int CLK_MHZ = 200;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int TICKS_W = 5;

  // Duration settings, in ticks of 100 ms
  localparam logic [4:0] ON_T0 = 5'h02;
  localparam logic [4:0] ON_T1 = 5'h06;
  localparam logic [4:0] ON_T2 = 5'h08;
  localparam logic [4:0] ON_T3 = 5'h0C;
  localparam logic [4:0] OFF_T1 = 5'h06;
  localparam logic [4:0] OFF_T2 = 5'h0C;
  localparam logic [4:0] OFF_T3 = 5'h12;

  // Phase of one sink
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON = 3'b010,
    ST_OFF = 3'b100
  } sbt_phase_e;

  // Shared on-time code to ticks
  function automatic logic [4:0] sbt_on_ticks(input logic [1:0] code);
    case (code)
      2'h0: sbt_on_ticks = ON_T0;
      2'h1: sbt_on_ticks = ON_T1;
      2'h2: sbt_on_ticks = ON_T2;
      default: sbt_on_ticks = ON_T3;
    endcase
  endfunction

  // Dark-time code to ticks; zero means dark time disabled
  function automatic logic [4:0] sbt_off_ticks(input logic [1:0] code);
    case (code)
      2'h0: sbt_off_ticks = 5'h00;
      2'h1: sbt_off_ticks = OFF_T1;
      2'h2: sbt_off_ticks = OFF_T2;
      default: sbt_off_ticks = OFF_T3;
    endcase
  endfunction

endpackage

/* core/sbt_sink_phase.sv */
// Purpose: On/dark phase sequencer for one independent current sink
// Assumes: Enable and durations come from registers in the same clock domain
// Notes: Durations are latched at phase entry; edits act from the next phase, but dark code 00 acts at once
module sbt_sink_phase #(
  parameter int TICK_CYCLES = sbt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [4:0] on_len,
  input wire logic [4:0] off_len,
  // Sink drive
  output logic lit
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  // Refuse a timebase the prescaler cannot count
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  sbt_pkg::sbt_phase_e state, next_state;
  logic [PW-1:0] pre, next_pre;
  logic [4:0] tcnt, next_tcnt;
  logic [4:0] len, next_len;
  logic next_lit;
  logic tick;

  // Phase sequencing on the timebase tick
  always_comb begin
    next_state = state;
    next_pre = pre;
    next_tcnt = tcnt;
    next_len = len;
    tick = (pre == PW'(TICK_CYCLES - 1));
    case (state)
      sbt_pkg::ST_IDLE: begin
        if (en) begin
          next_state = sbt_pkg::ST_ON;
          next_pre = '0;
          next_tcnt = '0;
          next_len = on_len;
        end
      end
      sbt_pkg::ST_ON: begin
        if (off_len == 5'h00) begin
          next_pre = '0;
          next_tcnt = '0;
        end else if (tick) begin
          next_pre = '0;
          if (5'(tcnt + 5'h01) >= len) begin
            next_state = sbt_pkg::ST_OFF;
            next_tcnt = '0;
            next_len = off_len;
          end else begin
            next_tcnt = 5'(tcnt + 5'h01);
          end
        end else begin
          next_pre = PW'(pre + 1'b1);
        end
      end
      sbt_pkg::ST_OFF: begin
        if (off_len == 5'h00) begin
          next_state = sbt_pkg::ST_ON;
          next_pre = '0;
          next_tcnt = '0;
          next_len = on_len;
        end else if (tick) begin
          next_pre = '0;
          if (5'(tcnt + 5'h01) >= len) begin
            next_state = sbt_pkg::ST_ON;
            next_tcnt = '0;
            next_len = on_len;
          end else begin
            next_tcnt = 5'(tcnt + 5'h01);
          end
        end else begin
          next_pre = PW'(pre + 1'b1);
        end
      end
      default: begin
        next_state = sbt_pkg::ST_IDLE;
      end
    endcase
    if (!en) begin
      next_state = sbt_pkg::ST_IDLE;
      next_pre = '0;
      next_tcnt = '0;
      next_len = '0;
    end
    next_lit = (next_state == sbt_pkg::ST_ON);
  end

  // Phase registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sbt_pkg::ST_IDLE;
      pre <= '0;
      tcnt <= '0;
      len <= '0;
      lit <= 1'b0;
    end else begin
      state <= next_state;
      pre <= next_pre;
      tcnt <= next_tcnt;
      len <= next_len;
      lit <= next_lit;
    end
  end

  // Cycles spent in the current timed phase, for checking only
  logic [31:0] span;
  always_ff @(posedge clk) begin
    if (rst || state != next_state || (state == sbt_pkg::ST_ON && off_len == 5'h00)) begin
      span <= '0;
    end else begin
      span <= span + 32'h1;
    end
  end

  property p_on_len;
    @(posedge clk) disable iff (rst)
    (state == sbt_pkg::ST_ON && next_state == sbt_pkg::ST_OFF)
      |-> span == 32'(len) * 32'(TICK_CYCLES) - 32'h1;
  endproperty
  a_on_len: assert property (p_on_len) else $error("on phase length wrong");

  property p_off_len;
    @(posedge clk) disable iff (rst)
    (state == sbt_pkg::ST_OFF && next_state == sbt_pkg::ST_ON && off_len != 5'h00)
      |-> span == 32'(len) * 32'(TICK_CYCLES) - 32'h1;
  endproperty
  a_off_len: assert property (p_off_len) else $error("dark phase length wrong");

  property p_steady;
    @(posedge clk) disable iff (rst)
    (state == sbt_pkg::ST_ON && en && off_len == 5'h00) |=> lit ##1 (lit || !$past(en));
  endproperty
  a_steady: assert property (p_steady) else $error("steady sink went dark");

  property p_disable;
    @(posedge clk) disable iff (rst)
    !en |=> (!lit && state == sbt_pkg::ST_IDLE && tcnt == 5'h00);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled sink not cleared");

  property p_restart;
    @(posedge clk) disable iff (rst)
    $rose(en) |=> (lit && state == sbt_pkg::ST_ON && pre == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("enable did not start on phase");

  c_blink_off: cover property (@(posedge clk) disable iff (rst)
    state == sbt_pkg::ST_ON ##1 state == sbt_pkg::ST_OFF);
  c_blink_on: cover property (@(posedge clk) disable iff (rst)
    state == sbt_pkg::ST_OFF ##1 state == sbt_pkg::ST_ON);
  c_steady: cover property (@(posedge clk) disable iff (rst)
    (state == sbt_pkg::ST_ON && off_len == 5'h00) [*4]);

endmodule

/* core/sbt_blink_timer.sv */
// Purpose: Blink timer for independent current sinks 5, 6 and 7
// Assumes: Register port is the decoded side of the serial control interface
// Notes: Sinks 1 to 4 keep their enable bits here but are timed elsewhere
//
// Summary of operation
// - Bits 7:6 pick the shared on time: 0.2, 0.6, 0.8, 1.2 s.
// - Enabled sink with dark time set lights for the on time, then goes dark.
// - Enabled sink with dark code 00 stays lit without blinking.
// - With dark time set, stay dark that long, relight for on time, repeat.
// - Sink 7 dark time in bits 5:4: off, 0.6, 1.2, 1.8 s.
// - Sink 6 dark time in bits 3:2, same four codes.
// - Sink 5 dark time in bits 1:0, same four codes.
// - Sinks enabled in one write start their sequences together.
// - Enable register holds one bit per sink, bit 6 sink 7 to bit 0 sink 1.
module sbt_blink_timer #(
  parameter int TICK_CYCLES = sbt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sink drive, bit 0 is sink 5
  output logic [2:0] sink_lit
);

  // Refuse a timebase too short to sequence
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  logic [6:0] sink_enable_register, next_sink_enable_register;
  logic [7:0] blink_time_upper_sinks, next_blink_time_upper_sinks;
  logic [7:0] next_reg_rdata;
  logic [4:0] shared_on_duration;
  logic [4:0] sink_dark_duration [sbt_pkg::SINK_COUNT];
  logic [2:0] sink_enable_bit;

  // Register writes and registered read data
  always_comb begin
    next_sink_enable_register = sink_enable_register;
    next_blink_time_upper_sinks = blink_time_upper_sinks;
    next_reg_rdata = reg_rdata;
    if (reg_wr && reg_addr == sbt_pkg::ADDR_SINK_ENABLE) begin
      next_sink_enable_register = reg_wdata[6:0];
    end
    if (reg_wr && reg_addr == sbt_pkg::ADDR_BLINK_TIME) begin
      next_blink_time_upper_sinks = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        sbt_pkg::ADDR_SINK_ENABLE: next_reg_rdata = {1'b0, sink_enable_register};
        sbt_pkg::ADDR_BLINK_TIME: next_reg_rdata = blink_time_upper_sinks;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sink_enable_register <= sbt_pkg::RST_SINK_ENABLE;
      blink_time_upper_sinks <= sbt_pkg::RST_BLINK_TIME;
      reg_rdata <= 8'h00;
    end else begin
      sink_enable_register <= next_sink_enable_register;
      blink_time_upper_sinks <= next_blink_time_upper_sinks;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Shared on time decode
  assign shared_on_duration = sbt_pkg::sbt_on_ticks(
    blink_time_upper_sinks[sbt_pkg::ON_FIELD_LSB +: 2]);

  // One sequencer per sink: sink 5 at index 0 up to sink 7 at index 2
  for (genvar i = 0; i < sbt_pkg::SINK_COUNT; i++) begin : g_sink
    logic [1:0] dark_code;
    // Dark-time field of this sink and its length in ticks
    assign dark_code = blink_time_upper_sinks[i * sbt_pkg::OFF_FIELD_STRIDE +: 2];
    assign sink_dark_duration[i] = sbt_pkg::sbt_off_ticks(dark_code);
    assign sink_enable_bit[i] = sink_enable_register[sbt_pkg::FIRST_SINK_EN_BIT + i];
    sbt_sink_phase #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_phase (
      .clk(clk),
      .rst(rst),
      .en(sink_enable_bit[i]),
      .on_len(shared_on_duration),
      .off_len(sink_dark_duration[i]),
      .lit(sink_lit[i])
    );

    // Dark code 00 keeps an enabled sink lit
    property p_steady_lit;
      @(posedge clk) disable iff (rst)
      (sink_enable_bit[i] && dark_code == 2'h0) |=> sink_lit[i];
    endproperty
    a_steady_lit: assert property (p_steady_lit) else $error("untimed sink dark");

    // A cleared enable darkens the sink on the next edge
    property p_cleared_dark;
      @(posedge clk) disable iff (rst)
      !sink_enable_bit[i] |=> !sink_lit[i];
    endproperty
    a_cleared_dark: assert property (p_cleared_dark) else $error("sink still lit");

    // A sink dark while enabled must be in a timed dark phase
    property p_timed_dark;
      @(posedge clk) disable iff (rst)
      (sink_enable_bit[i] && $past(sink_enable_bit[i]) && !sink_lit[i])
        |-> $past(dark_code) != 2'h0;
    endproperty
    a_timed_dark: assert property (p_timed_dark) else $error("untimed dark phase");

    // The sink lights only after its enable was set
    property p_lit_enabled;
      @(posedge clk) disable iff (rst)
      $rose(sink_lit[i]) |-> $past(sink_enable_bit[i]);
    endproperty
    a_lit_enabled: assert property (p_lit_enabled) else $error("lit while disabled");
  end

  property p_enable_write;
    @(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == sbt_pkg::ADDR_SINK_ENABLE)
      |=> sink_enable_register == $past(reg_wdata[6:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_same_start;
    @(posedge clk) disable iff (rst)
    ($rose(sink_enable_bit[0]) && $rose(sink_enable_bit[2]))
      |=> (sink_lit[0] && sink_lit[2]);
  endproperty
  a_same_start: assert property (p_same_start) else $error("sinks did not start together");

  property p_time_read;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == sbt_pkg::ADDR_BLINK_TIME)
      |=> reg_rdata == $past(blink_time_upper_sinks);
  endproperty
  a_time_read: assert property (p_time_read) else $error("timing readback wrong");

  // Reset clears both registers, the read data and every sink
  property p_reset_clear;
    @(posedge clk)
    rst |=> (sink_lit == 3'h0 && reg_rdata == 8'h00
      && sink_enable_register == sbt_pkg::RST_SINK_ENABLE
      && blink_time_upper_sinks == sbt_pkg::RST_BLINK_TIME);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

  // Enable readback carries a zero in the top bit
  property p_enable_read;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == sbt_pkg::ADDR_SINK_ENABLE)
      |=> reg_rdata == {1'b0, $past(sink_enable_register)};
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

  // Reads of unmapped offsets return zero
  property p_unmapped_read;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr != sbt_pkg::ADDR_SINK_ENABLE
      && reg_addr != sbt_pkg::ADDR_BLINK_TIME) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("stray read data");

  // Read data stands until the next read strobe
  property p_rdata_hold;
    @(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data drifted");

  // A timing write lands whole in the timing register
  property p_timing_write;
    @(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == sbt_pkg::ADDR_BLINK_TIME)
      |=> blink_time_upper_sinks == $past(reg_wdata);
  endproperty
  a_timing_write: assert property (p_timing_write) else $error("timing write lost");

  // Writes to unmapped offsets change neither register
  property p_unmapped_write;
    @(posedge clk) disable iff (rst)
    (reg_wr && reg_addr != sbt_pkg::ADDR_SINK_ENABLE
      && reg_addr != sbt_pkg::ADDR_BLINK_TIME)
      |=> ($stable(sink_enable_register) && $stable(blink_time_upper_sinks));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write");

  // Without a write strobe both registers hold
  property p_quiet_hold;
    @(posedge clk) disable iff (rst)
    !reg_wr |=> ($stable(sink_enable_register) && $stable(blink_time_upper_sinks));
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("register changed unasked");

  // Sinks 5 and 6 enabled together light together as well
  property p_pair_start;
    @(posedge clk) disable iff (rst)
    ($rose(sink_enable_bit[0]) && $rose(sink_enable_bit[1]))
      |=> (sink_lit[0] && sink_lit[1]);
  endproperty
  a_pair_start: assert property (p_pair_start) else $error("sinks 5 and 6 apart");

  c_group_start: cover property (@(posedge clk) disable iff (rst)
    $rose(sink_enable_bit[0]) && $rose(sink_enable_bit[1]) && $rose(sink_enable_bit[2]));
  c_time_write: cover property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == sbt_pkg::ADDR_BLINK_TIME && reg_wdata[5:4] != 2'h0);

endmodule

/* tb/sbt_blink_timer_tb_top.sv */
// Purpose: Self-checking bench for the sink blink timer
// Assumes: Short tick of 4 clocks, inputs driven on the falling edge
// Notes: Drivers queue expectations, a monitor pops and compares them
module sbt_blink_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Tick length of the shortened timebase
  localparam int T = 4;

  // Design ports
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [2:0] sink_lit;

  // Bench state
  logic rd_d = 1'b0;
  logic probe = 1'b0;
  logic [7:0] rd_q[$];
  logic [7:0] lit_q[$];
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h00000003;

  // Clock of 5 ns
  always #2.5 clk = ~clk;

  sbt_blink_timer #(.TICK_CYCLES(T)) i_sbt_blink_timer (
    .clk(clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sink_lit(sink_lit)
  );

  // Xorshift source of random values
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // On length in ticks for each on code
  function automatic int on_tk(input int c);
    case (c)
      0: return 2;
      1: return 6;
      2: return 8;
      default: return 12;
    endcase
  endfunction

  // Dark length in ticks for each dark code
  function automatic int off_tk(input int c);
    case (c)
      0: return 0;
      1: return 6;
      2: return 12;
      default: return 18;
    endcase
  endfunction

  // Compare one value and count it
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One register write, then one idle cycle
  task wr(input logic [7:0] addr, input logic [7:0] data);
    probe = 1'b0;
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  // One register read with its expected answer queued
  task rd(input logic [7:0] addr, input logic [7:0] exp);
    probe = 1'b0;
    reg_rd = 1'b1;
    reg_addr = addr;
    rd_q.push_back(exp);
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask

  // Queue the sink drive expected at the next edge
  task lit(input logic [2:0] exp);
    lit_q.push_back({5'h00, exp});
    probe = 1'b1;
    @(negedge clk);
  endtask

  // Monitor: read data one cycle after the strobe, sink drive when probed
  always @(posedge clk) begin
    if (rd_d) check("reg_rdata", reg_rdata, rd_q.pop_front());
    if (probe) check("sink_lit", {5'h00, sink_lit}, lit_q.pop_front());
    rd_d <= reg_rd;
  end

  // Verdict and end of run
  task end_of_test();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] en;
    logic [7:0] a;
    logic [2:0] e;
    logic [7:0] t;
    int p;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // Reset values, unmapped place, read back
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    lit(3'b000);
    r = xs();
    a = {3'b001, r[12:8]};
    wr(a, r[7:0]);
    rd(a, 8'h00);
    r = xs();
    wr(8'h11, r[7:0]);
    rd(8'h11, r[7:0]);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h7F);
    $display("Test registers done");
    // Dark codes 00: lit without blinking, dark at once on disable
    wr(8'h10, 8'h00);
    wr(8'h11, 8'hC0);
    wr(8'h10, 8'h70);
    repeat (100) lit(3'b111);
    wr(8'h10, 8'h00);
    lit(3'b000);
    $display("Test steady done");
    // Every on code, timed dark codes rotated over sinks 5, 6 and 7
    for (int j = 0; j < 4; j++) begin
      r = xs();
      en = (r[7:0] & 8'h7F) | 8'h10;
      t = {j[1:0], 6'h00};
      for (int k = 0; k < 3; k++) begin
        t[2 * k +: 2] = 2'((j + k) % 3 + 1);
      end
      wr(8'h11, t);
      wr(8'h10, en);
      for (int n = 0; n < 200; n++) begin
        for (int k = 0; k < 3; k++) begin
          p = (on_tk(j) + off_tk((j + k) % 3 + 1)) * T;
          e[k] = en[4 + k] && ((n % p) < on_tk(j) * T);
        end
        lit(e);
      end
      wr(8'h10, 8'h00);
      lit(3'b000);
      rd(8'h10, 8'h00);
      $display("Test blink on code %0d done", j);
    end
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
